// ===== lpst_pkg.sv
// Package for the low power sleep timer: offsets, fields, reset values, types
package lpst_pkg;

  localparam int unsigned LPST_AW = 32;
  localparam int unsigned LPST_DW = 32;

  // Register byte addresses
  localparam logic [31:0] LPST_ADDR_CLKEN = 32'h4000_0008;
  localparam logic [31:0] LPST_ADDR_CFG = 32'h4000_600C;
  localparam logic [31:0] LPST_ADDR_CNTH = 32'h4000_6010;
  localparam logic [31:0] LPST_ADDR_CNTL = 32'h4000_6014;
  localparam logic [31:0] LPST_ADDR_MAH = 32'h4000_6018;
  localparam logic [31:0] LPST_ADDR_MAL = 32'h4000_601C;
  localparam logic [31:0] LPST_ADDR_MBH = 32'h4000_6020;
  localparam logic [31:0] LPST_ADDR_MBL = 32'h4000_6024;
  localparam logic [31:0] LPST_ADDR_FLAGS = 32'h4000_A014;
  localparam logic [31:0] LPST_ADDR_MASK = 32'h4000_A054;

  // Configuration field positions
  localparam int unsigned LPST_CFG_DOWN_BIT = 12;
  localparam int unsigned LPST_CFG_RUN_BIT = 11;
  localparam int unsigned LPST_CFG_FREEZE_BIT = 10;
  localparam int unsigned LPST_CFG_PRE_LSB = 4;
  localparam int unsigned LPST_CFG_PRE_W = 4;
  localparam int unsigned LPST_CFG_SRC_BIT = 0;

  // Flag and mask bit positions
  localparam int unsigned LPST_EV_OVF = 0;
  localparam int unsigned LPST_EV_MA = 1;
  localparam int unsigned LPST_EV_MB = 2;
  localparam int unsigned LPST_EV_W = 3;

  // Clock enable bit positions
  localparam int unsigned LPST_CLKEN_XTAL_BIT = 0;
  localparam int unsigned LPST_CLKEN_RC_BIT = 1;

  // Reset values
  localparam logic [31:0] LPST_RST_CLKEN = 32'h0000_0002;
  localparam logic [31:0] LPST_RST_CFG = 32'h0000_0400;
  localparam logic [15:0] LPST_RST_MATCH_HALF = 16'hFFFF;

  // Run-change latency in selected timer clock periods
  localparam int unsigned LPST_RUN_SYNC_TICKS = 2;

  typedef struct packed {
    logic count_down_sel;
    logic timer_run;
    logic halt_freeze;
    logic [LPST_CFG_PRE_W-1:0] prescale_exponent;
    logic tick_source_sel;
  } lpst_cfg_t;

  typedef struct packed {
    logic rc_clock_keep_on;
    logic crystal_clock_on;
  } lpst_clken_t;

  typedef struct packed {
    logic match_b_event;
    logic match_a_event;
    logic overflow_event;
  } lpst_events_t;

endpackage : lpst_pkg

// ===== lpst_sleep_timer.sv
// Low power sleep timer: prescaler, 32-bit counter, two matches, flags, clock enables
`timescale 1ns/100ps

// Block overview
//
// Clocking
//   Everything runs on clk. The two slow reference clocks arrive on pins
//   and are never used as clocks: each passes two flip-flops and its rising
//   edge becomes a one-cycle enable. The selected enable is the timer tick.
//   The pin rate must stay well below half the clk rate, or edges are lost.
//
// Tick path
//   Selected tick -> run pipe -> freeze gate -> prescaler -> counter step.
//   The run pipe shifts only on the selected tick, not on every clk, so a change of
//   the run bit shows after two or three reference periods. That keeps a
//   stop or start aligned to the slow clock, as software expects.
//
// Prescaler
//   A free counter of active ticks; the step fires when its low N bits are
//   all ones, so one step per 2^N ticks. It restarts while the timer is
//   stopped, so the first period after a start is always a full one.
//   Freeze holds the prescaler too, so no partial period leaks through.
//
// Counter
//   Counts up or down by one per step. Stopping leaves the value in place;
//   only reset clears it. Software cannot write it.
//
// Wrap
//   Up: the step from all ones to zero sets the overflow flag.
//   Down: the step from zero to all ones sets it.
//
// Matches
//   Each channel compares the count after the step with its 32-bit value,
//   so one crossing gives one event, whatever the direction.
//   The lower half is written to a hold register first; the upper write
//   loads both halves at once, so the active value never shows a torn mix.
//   Writes while running are taken as issued. A value written near the
//   current count may fire at once, which is why software masks first.
//
// Flags and request
//   Flags are sticky; writing one clears a bit. An event in the same cycle
//   as its clear wins, so no event is ever lost to a late clear.
//   The request output is the OR of flags under the mask, a pure level.
//   Event pulses are a registered copy of the set strobes, for wake logic
//   that must see an event even while its flag is already set.
//
// Counter reads
//   The upper half read latches the lower half in the same cycle, so the
//   pair is coherent. A lower half read alone returns a stale snapshot.
//
// Configuration lock
//   Direction, prescaler and source are only taken while the stored run
//   bit is zero. A write that sets run and changes them from a stopped
//   timer is taken whole. Run and freeze are always writable.
//
// Clock enables and sleep levels
//   The enables are plain read-write bits passed out to the clock gating.
//   The sleep level outputs are combinational and only high while a deep
//   sleep is requested; exactly one of them is then high.
//
// Register port
//   Read data is registered and stands for one cycle after the strobe,
//   zero otherwise. Unmapped reads give zero; unmapped writes are dropped.
//   The port never stalls, so strobes may come back to back.
//
// Limitations
//   No watchdog, no power sequencing and no wake recording here.
//   The halt input is a level; a glitch shorter than one clk cycle may
//   be missed, which only delays a freeze by one tick.
//

// How it works
// - A 32-bit counter with two match channels and wrap detection, each flagging an event.
// - Direction bit 12: zero counts up, one counts down.
// - Run bit 11: one runs the timer, zero stops it.
// - Direction, prescaler and source accept writes only while the run bit is zero.
// - A run bit change takes effect two to three selected timer clock periods later.
// - Freeze bit 10 set holds the counter while the CPU is debug halted.
// - Prescaler field bits 7..4 divides the selected tick by two to the N.
// - Source bit zero picks the 1 kHz RC tick, one picks the 32 kHz tick.
// - Reading the upper half returns bits 31..16 and latches the lower half.
// - Writing a match lower half only fills a hold register.
// - Writing a match upper half loads bits 31..16 and copies the held lower half.
// - Match values should change only while stopped; changes while running may misfire.
// - Flags: bit 2 match B, bit 1 match A, bit 0 overflow; write one clears.
// - Mask register bits 2..0 pair with the match B, match A and overflow flags.
// - Deep sleep entry picks the deeper level when the RC keep bit is zero.
// - Clock enable bit 1 keeps the RC clock in deep sleep; bit 0 enables the crystal.
module lpst_sleep_timer
  import lpst_pkg::*;
#(
  parameter int unsigned CNT_W = 32,
  parameter int unsigned PRE_W = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [LPST_AW-1:0] reg_addr,
  input wire logic [LPST_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [LPST_DW-1:0] reg_rdata,
  input wire logic ms_tick_pin,
  input wire logic xtal_tick_pin,
  input wire logic cpu_halted_pin,
  input wire logic deep_sleep_request,
  output logic irq,
  output lpst_events_t event_pulse,
  output lpst_clken_t clock_enables,
  output logic deepest_sleep_level,
  output logic shallow_deep_sleep_level
);

  // Two-flop synchronisers for the asynchronous tick sources and the halt level
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [1:0] tick_dly_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      tick_dly_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= {cpu_halted_pin, xtal_tick_pin, ms_tick_pin};
      sync2_reg <= sync1_reg;
      tick_dly_reg <= sync2_reg[1:0];
    end
  end

  // Rising edges of the reference ticks, one clk cycle each
  wire logic ms_rise = sync2_reg[0] & ~tick_dly_reg[0];
  wire logic xtal_rise = sync2_reg[1] & ~tick_dly_reg[1];
  wire logic cpu_halted = sync2_reg[2];

  // Register state
  lpst_cfg_t cfg_reg;
  lpst_clken_t clken_reg;
  lpst_events_t flags_reg;
  lpst_events_t mask_reg;
  logic [CNT_W-1:0] count_reg;
  logic [15:0] low_latch_reg;
  logic [31:0] match_a_reg;
  logic [31:0] match_b_reg;
  logic [15:0] hold_a_reg;
  logic [15:0] hold_b_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [LPST_RUN_SYNC_TICKS-1:0] run_pipe_reg;
  logic [LPST_DW-1:0] rdata_reg;

  // Address decode, shared by reads and writes
  function automatic logic hit(input logic [LPST_AW-1:0] a, input logic [31:0] ref_addr);
    hit = (a == ref_addr);
  endfunction : hit

  wire logic wr_cfg = reg_write & hit(reg_addr, LPST_ADDR_CFG);
  wire logic wr_clken = reg_write & hit(reg_addr, LPST_ADDR_CLKEN);
  wire logic wr_mah = reg_write & hit(reg_addr, LPST_ADDR_MAH);
  wire logic wr_mal = reg_write & hit(reg_addr, LPST_ADDR_MAL);
  wire logic wr_mbh = reg_write & hit(reg_addr, LPST_ADDR_MBH);
  wire logic wr_mbl = reg_write & hit(reg_addr, LPST_ADDR_MBL);
  wire logic wr_flags = reg_write & hit(reg_addr, LPST_ADDR_FLAGS);
  wire logic wr_mask = reg_write & hit(reg_addr, LPST_ADDR_MASK);
  wire logic rd_cnth = reg_read & hit(reg_addr, LPST_ADDR_CNTH);

  // Selected timer tick and its run state seen through the sync pipe
  wire logic src_tick = cfg_reg.tick_source_sel ? xtal_rise : ms_rise;
  wire logic run_eff = run_pipe_reg[LPST_RUN_SYNC_TICKS-1];
  wire logic frozen = cfg_reg.halt_freeze & cpu_halted;
  wire logic advance = src_tick & run_eff & ~frozen;

  // Prescaler terminal count: the low N bits all ones gives 2^N ticks
  wire logic [PRE_W-1:0] pre_mask =
    PRE_W'((32'h1 << cfg_reg.prescale_exponent) - 32'h1);
  wire logic pre_done = ((pre_reg & pre_mask) == pre_mask);
  wire logic cnt_step = advance & pre_done;

  // Counter next value and wrap detection
  wire logic [CNT_W-1:0] cnt_end = cfg_reg.count_down_sel ? '0 : '1;
  wire logic [CNT_W-1:0] cnt_up = count_reg + CNT_W'(1);
  wire logic [CNT_W-1:0] cnt_dn = count_reg - CNT_W'(1);
  wire logic [CNT_W-1:0] cnt_next = cfg_reg.count_down_sel ? cnt_dn : cnt_up;
  wire logic wrap_hit = cnt_step & (count_reg == cnt_end);

  // Match on the new count value so the event fires once per crossing
  wire logic match_a_hit = cnt_step & (cnt_next == CNT_W'(match_a_reg));
  wire logic match_b_hit = cnt_step & (cnt_next == CNT_W'(match_b_reg));

  lpst_events_t ev_set;
  assign ev_set = '{match_b_event: match_b_hit, match_a_event: match_a_hit,
                    overflow_event: wrap_hit};

  // Write-one-to-clear, but a new event in the same cycle wins
  wire logic [LPST_EV_W-1:0] clr_bits = wr_flags ? reg_wdata[LPST_EV_W-1:0] : 3'h0;
  wire logic [LPST_EV_W-1:0] flags_next = (flags_reg & ~clr_bits) | ev_set;

  // Configuration: locked fields only move while the run bit is zero
  wire logic cfg_unlocked = ~cfg_reg.timer_run;
  lpst_cfg_t cfg_next;
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_cfg)
    begin
      cfg_next.timer_run = reg_wdata[LPST_CFG_RUN_BIT];
      cfg_next.halt_freeze = reg_wdata[LPST_CFG_FREEZE_BIT];
      if (cfg_unlocked)
      begin
        cfg_next.count_down_sel = reg_wdata[LPST_CFG_DOWN_BIT];
        cfg_next.prescale_exponent = reg_wdata[LPST_CFG_PRE_LSB +: LPST_CFG_PRE_W];
        cfg_next.tick_source_sel = reg_wdata[LPST_CFG_SRC_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Every field taken from the documented reset word
      cfg_reg <= '{count_down_sel: LPST_RST_CFG[LPST_CFG_DOWN_BIT],
                   timer_run: LPST_RST_CFG[LPST_CFG_RUN_BIT],
                   halt_freeze: LPST_RST_CFG[LPST_CFG_FREEZE_BIT],
                   prescale_exponent: LPST_RST_CFG[LPST_CFG_PRE_LSB +: LPST_CFG_PRE_W],
                   tick_source_sel: LPST_RST_CFG[LPST_CFG_SRC_BIT]};
      clken_reg <= lpst_clken_t'(LPST_RST_CLKEN[1:0]);
      mask_reg <= '0;
      flags_reg <= '0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      if (wr_clken)
        clken_reg <= lpst_clken_t'(reg_wdata[1:0]);
      if (wr_mask)
        mask_reg <= lpst_events_t'(reg_wdata[LPST_EV_W-1:0]);
      flags_reg <= lpst_events_t'(flags_next);
    end
  end

  // Run bit reaches the counter only on selected ticks, so enable latency is 2..3 ticks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      run_pipe_reg <= '0;
    else if (src_tick)
      run_pipe_reg <= {run_pipe_reg[LPST_RUN_SYNC_TICKS-2:0], cfg_reg.timer_run};
  end

  // Prescaler and counter; the prescaler restarts whenever the timer is stopped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pre_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (!run_eff)
        pre_reg <= '0;
      else if (advance)
        pre_reg <= pre_done ? '0 : pre_reg + PRE_W'(1);
      if (cnt_step)
        count_reg <= cnt_next;
    end
  end

  // Match registers through hold halves; writes while running are taken as issued
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hold_a_reg <= LPST_RST_MATCH_HALF;
      hold_b_reg <= LPST_RST_MATCH_HALF;
      match_a_reg <= {LPST_RST_MATCH_HALF, LPST_RST_MATCH_HALF};
      match_b_reg <= {LPST_RST_MATCH_HALF, LPST_RST_MATCH_HALF};
    end
    else
    begin
      if (wr_mal)
        hold_a_reg <= reg_wdata[15:0];
      if (wr_mbl)
        hold_b_reg <= reg_wdata[15:0];
      if (wr_mah)
        match_a_reg <= {reg_wdata[15:0], hold_a_reg};
      if (wr_mbh)
        match_b_reg <= {reg_wdata[15:0], hold_b_reg};
    end
  end

  // Low half snapshot taken on the upper half read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      low_latch_reg <= '0;
    else if (rd_cnth)
      low_latch_reg <= count_reg[15:0];
  end

  // Read mux; unmapped addresses read zero
  logic [LPST_DW-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    unique case (1'b1)
      hit(reg_addr, LPST_ADDR_CFG):
      begin
        rd_mux[LPST_CFG_DOWN_BIT] = cfg_reg.count_down_sel;
        rd_mux[LPST_CFG_RUN_BIT] = cfg_reg.timer_run;
        rd_mux[LPST_CFG_FREEZE_BIT] = cfg_reg.halt_freeze;
        rd_mux[LPST_CFG_PRE_LSB +: LPST_CFG_PRE_W] = cfg_reg.prescale_exponent;
        rd_mux[LPST_CFG_SRC_BIT] = cfg_reg.tick_source_sel;
      end
      hit(reg_addr, LPST_ADDR_CLKEN): rd_mux[1:0] = clken_reg;
      hit(reg_addr, LPST_ADDR_CNTH): rd_mux[15:0] = count_reg[31:16];
      hit(reg_addr, LPST_ADDR_CNTL): rd_mux[15:0] = low_latch_reg;
      hit(reg_addr, LPST_ADDR_MAH): rd_mux[15:0] = match_a_reg[31:16];
      hit(reg_addr, LPST_ADDR_MAL): rd_mux[15:0] = match_a_reg[15:0];
      hit(reg_addr, LPST_ADDR_MBH): rd_mux[15:0] = match_b_reg[31:16];
      hit(reg_addr, LPST_ADDR_MBL): rd_mux[15:0] = match_b_reg[15:0];
      hit(reg_addr, LPST_ADDR_FLAGS): rd_mux[LPST_EV_W-1:0] = flags_reg;
      hit(reg_addr, LPST_ADDR_MASK): rd_mux[LPST_EV_W-1:0] = mask_reg;
      default: rd_mux = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else
      rdata_reg <= reg_read ? rd_mux : '0;
  end

  // Event pulses for wake logic, registered
  lpst_events_t pulse_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulse_reg <= '0;
    else
      pulse_reg <= ev_set;
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(flags_reg & mask_reg);
  assign event_pulse = pulse_reg;
  assign clock_enables = clken_reg;
  // Sleep level choice only matters while a deep sleep is requested
  assign deepest_sleep_level = deep_sleep_request & ~clken_reg.rc_clock_keep_on;
  assign shallow_deep_sleep_level = deep_sleep_request & clken_reg.rc_clock_keep_on;

endmodule : lpst_sleep_timer

// ===== lpst_sleep_timer_assertions.sv
// Checker for the sleep timer register port and status outputs
`timescale 1ns/100ps
module lpst_chk
  import lpst_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [LPST_AW-1:0] reg_addr,
  input wire logic [LPST_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [LPST_DW-1:0] reg_rdata,
  input wire logic deep_sleep_request,
  input wire logic irq,
  input wire lpst_events_t event_pulse,
  input wire lpst_clken_t clock_enables,
  input wire logic deepest_sleep_level,
  input wire logic shallow_deep_sleep_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Mask write, one idle cycle, then its read back
  sequence s_wm; reg_write && reg_addr == LPST_ADDR_MASK; endsequence
  sequence s_rm; reg_read && reg_addr == LPST_ADDR_MASK; endsequence
  property p_rd_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
  property p_mask_rb;
    s_wm ##1 !reg_write ##1 s_rm |=> reg_rdata == {29'h0, $past(reg_wdata[2:0], 3)};
  endproperty
  property p_ck_wr;
    $past(reg_write && reg_addr == LPST_ADDR_CLKEN) |-> clock_enables == $past(reg_wdata[1:0]);
  endproperty
  property p_ck_hold;
    !$past(reg_write && reg_addr == LPST_ADDR_CLKEN) |-> $stable(clock_enables);
  endproperty
  property p_ck_rd;
    reg_read && reg_addr == LPST_ADDR_CLKEN |=> reg_rdata == {30'h0, $past(clock_enables)};
  endproperty
  property p_deep; deepest_sleep_level == (deep_sleep_request && !clock_enables[1]); endproperty
  property p_shal; shallow_deep_sleep_level == (deep_sleep_request && clock_enables[1]); endproperty
  property p_pulse; |event_pulse |=> event_pulse == 3'h0; endproperty
  // Flags only rise from events, so irq rises only near a pulse or a mask write
  property p_irq_up;
    $rose(irq) && !$past(reg_write) |-> $past(|event_pulse) or (##[0:1] |event_pulse);
  endproperty
  property p_irq_dn; $fell(irq) |-> $past(reg_write); endproperty
  property p_flag_rd; reg_read && reg_addr == LPST_ADDR_FLAGS |=> reg_rdata[31:3] == 29'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_mask_rb: assert property (p_mask_rb) else $error("mask read back wrong");
  a_ck_wr: assert property (p_ck_wr) else $error("clock enables not loaded");
  a_ck_hold: assert property (p_ck_hold) else $error("clock enables moved");
  a_ck_rd: assert property (p_ck_rd) else $error("clock enables read wrong");
  a_deep: assert property (p_deep) else $error("deepest level wrong");
  a_shal: assert property (p_shal) else $error("shallow level wrong");
  a_pulse: assert property (p_pulse) else $error("event pulse too long");
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
  a_flag_rd: assert property (p_flag_rd) else $error("flag upper bits set");
endmodule : lpst_chk

bind lpst_sleep_timer lpst_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .deep_sleep_request(deep_sleep_request), .irq(irq), .event_pulse(event_pulse),
  .clock_enables(clock_enables), .deepest_sleep_level(deepest_sleep_level),
  .shallow_deep_sleep_level(shallow_deep_sleep_level));

// ===== low_power_sleep_timer_tb_top.sv
// Self-checking bench for the sleep timer
`timescale 1ns/100ps
module low_power_sleep_timer_tb_top
  import lpst_pkg::*;
;
  logic clk = 0, rst = 1, reg_write = 0, reg_read = 0, dsr = 0, halt = 0, mt = 0, xt = 0;
  logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rd_last, r, d;
  logic irq, deep_lvl, shal_lvl, rd_v = 0;
  lpst_events_t ev;
  lpst_clken_t cke;
  logic [32:0] q[$];
  logic [3:0] tcnt = 4'h0;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  lpst_sleep_timer u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ms_tick_pin(mt),
    .xtal_tick_pin(xt), .cpu_halted_pin(halt), .deep_sleep_request(dsr), .irq(irq),
    .event_pulse(ev), .clock_enables(cke), .deepest_sleep_level(deep_lvl),
    .shallow_deep_sleep_level(shal_lvl));
  initial forever #50 clk = ~clk;
  // Fast reference ticks keep the run short: 8 and 4 clock periods
  always @(posedge clk)
  begin
    tcnt <= tcnt + 4'h1;
    mt <= tcnt[2];
    xt <= tcnt[1];
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      test_done;
    end
  end
  // Oldest note is taken when read data stands; bit 32 marks a capture only
  always @(posedge clk)
  begin
    rd_v <= reg_read;
    if (rd_v)
    begin
      rd_last = reg_rdata;
      if (!q[0][32]) check("rdata", reg_rdata, q[0][31:0]);
      void'(q.pop_front());
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(logic [31:0] ad, logic [31:0] dt);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= dt;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(logic [31:0] ad, logic [31:0] ex, logic ig);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= ad;
    q.push_back({ig, ex});
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : rd
  // Upper half first so the lower half is coherent
  task automatic cnt(output logic [31:0] v);
    rd(LPST_ADDR_CNTH, 32'h0, 1'b1);
    rd(LPST_ADDR_CNTL, 32'h0, 1'b1);
    @(posedge clk);
    #1 v = rd_last;
  endtask : cnt
  // Count change across a fixed 45-cycle gap between lower reads
  task automatic meas(output logic [31:0] dv);
    logic [31:0] a, b;
    cnt(a);
    repeat (40) @(posedge clk);
    cnt(b);
    dv = b - a;
  endtask : meas
  task automatic wait_ev(int b);
    while (ev[b] !== 1'b1) @(negedge clk);
  endtask : wait_ev
  task automatic test_done;
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  initial
  begin
    logic [31:0] ra [11] = '{LPST_ADDR_CFG, LPST_ADDR_CLKEN, LPST_ADDR_CNTH, LPST_ADDR_CNTL,
      LPST_ADDR_MAH, LPST_ADDR_MAL, LPST_ADDR_MBH, LPST_ADDR_MBL, LPST_ADDR_FLAGS,
      LPST_ADDR_MASK, 32'h4000_6028};
    logic [31:0] re [11] = '{32'h400, 32'h2, 0, 0, 32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF, 0, 0, 0};
    logic [31:0] mh [2] = '{LPST_ADDR_MAH, LPST_ADDR_MBH};
    logic [31:0] ml [2] = '{LPST_ADDR_MAL, LPST_ADDR_MBL};
    logic [31:0] mv [2] = '{32'h5, 32'h3};
    r = $urandom(32'h3703BACF);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 11; i++) rd(ra[i], re[i], 1'b0);
    // Every clock enable code with a random sleep request
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      wr(LPST_ADDR_CLKEN, i);
      dsr <= r[0];
      rd(LPST_ADDR_CLKEN, i, 1'b0);
      @(negedge clk);
      check("deep", deep_lvl, r[0] & ~i[1] ? 32'h1 : 32'h0);
      check("shallow", shal_lvl, r[0] & i[1] ? 32'h1 : 32'h0);
    end
    r = $urandom;
    wr(LPST_ADDR_MASK, {29'h0, r[2:0]});
    rd(LPST_ADDR_MASK, {29'h0, r[2:0]}, 1'b0);
    // Lower half waits in the hold register until the upper write
    for (int c = 0; c < 2; c++)
    begin
      wr(ml[c], mv[c]);
      rd(ml[c], 32'hFFFF, 1'b0);
      wr(mh[c], 32'h0);
      rd(mh[c], 32'h0, 1'b0);
      rd(ml[c], mv[c], 1'b0);
    end
    wr(LPST_ADDR_MASK, 32'h7);
    wr(LPST_ADDR_CFG, 32'h800);
    wait_ev(2);
    wait_ev(1);
    @(negedge clk);
    check("irq", irq, 32'h1);
    rd(LPST_ADDR_FLAGS, 32'h6, 1'b0);
    wr(LPST_ADDR_CFG, 32'h1811);
    rd(LPST_ADDR_CFG, 32'h800, 1'b0);
    wr(LPST_ADDR_FLAGS, 32'h6);
    rd(LPST_ADDR_FLAGS, 32'h0, 1'b0);
    check("irq", irq, 32'h0);
    meas(d);
    check("up", 32'(d inside {32'h5, 32'h6}), 32'h1);
    // Stopped timer holds its count
    wr(LPST_ADDR_CFG, 32'h0);
    repeat (30) @(posedge clk);
    meas(d);
    check("stop", d, 32'h0);
    // Down on the faster tick, divided by two
    wr(LPST_ADDR_CFG, 32'h1811);
    rd(LPST_ADDR_CFG, 32'h1811, 1'b0);
    wait_ev(0);
    rd(LPST_ADDR_FLAGS, 32'h7, 1'b0);
    meas(d);
    check("down", 32'(-d inside {32'h5, 32'h6}), 32'h1);
    halt <= 1'b1;
    wr(LPST_ADDR_CFG, 32'h1C11);
    repeat (10) @(posedge clk);
    meas(d);
    check("freeze", d, 32'h0);
    wr(LPST_ADDR_CFG, 32'h1811);
    repeat (10) @(posedge clk);
    meas(d);
    check("halted run", 32'(-d inside {32'h5, 32'h6}), 32'h1);
    test_done;
  end
endmodule : low_power_sleep_timer_tb_top
